// [core/i2cms_cfg.svh]
`ifndef I2CMS_CFG_SVH
`define I2CMS_CFG_SVH

// Register byte addresses
`define I2CMS_ADDR_RELOAD 8'h00
`define I2CMS_ADDR_BUF 8'h04
`define I2CMS_ADDR_CTL1 8'h08
`define I2CMS_ADDR_CTL2 8'h0c
`define I2CMS_ADDR_CTL3 8'h10
`define I2CMS_ADDR_STAT 8'h14
`define I2CMS_ADDR_FLAGS 8'h18

// Field positions
`define I2CMS_WCOL_BIT 7
`define I2CMS_EN_BIT 5
`define I2CMS_CKP_BIT 4
`define I2CMS_FINISH_BIT 2
`define I2CMS_STOP_SEEN_BIT 4
`define I2CMS_BUSY_BIT 2
`define I2CMS_BF_BIT 0
`define I2CMS_COLL_BIT 0
`define I2CMS_IRQ_BIT 1

// Mode codes and reset values
`define I2CMS_MODE_I2C_MST 4'h8
`define I2CMS_MODE_SPI_MST 4'ha
`define I2CMS_RST8 8'h00
`define I2CMS_RST_PHASE 5'h00

// Four clocks per counter step
`define I2CMS_PRESCALE_LAST 2'h3
// Clock half periods per byte
`define I2CMS_PHASES_I2C 5'h12
`define I2CMS_PHASES_SPI 5'h10

`endif

// [core/i2cms_pkg.sv]
package i2cms_pkg;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        I2CMS_IDLE = 7'h01,
        I2CMS_SHIFT = 7'h02,
        I2CMS_PULL_SDA = 7'h04,
        I2CMS_SDA_CNT = 7'h08,
        I2CMS_REL_SCL = 7'h10,
        I2CMS_SCL_CNT = 7'h20,
        I2CMS_REL_SDA = 7'h40
    } i2cms_state_t;

endpackage

// [core/i2cms_rate_counter.sv]
`timescale 1ns/1ns
`include "i2cms_cfg.svh"

module i2cms_rate_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [7:0] reload_value,
    output logic timeout
);

    logic [1:0] pre;
    logic [7:0] count;
    logic armed;
    logic [1:0] next_pre;
    logic [7:0] next_count;
    logic next_armed;
    logic tick;

    // One step per instruction cycle
    assign tick = (pre == `I2CMS_PRESCALE_LAST);
    assign timeout = armed && tick && (count == `I2CMS_RST8);

    // Load, count down, stop at zero
    always_comb begin
        next_pre = pre + 2'h1;
        next_count = count;
        next_armed = armed;
        if (load) begin
            next_pre = 2'h0;
            next_count = reload_value;
            next_armed = 1'b1;
        end else if (armed && tick) begin
            if (count == `I2CMS_RST8) begin
                next_armed = 1'b0;
            end else begin
                next_count = count - 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 2'h0;
            count <= `I2CMS_RST8;
            armed <= 1'b0;
        end else begin
            pre <= next_pre;
            count <= next_count;
            armed <= next_armed;
        end
    end

endmodule

// [core/i2cms_stop_core.sv]
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "i2cms_cfg.svh"

module i2cms_stop_core
    import i2cms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_clock_line_i,
    output logic bus_clock_line_o,
    output logic bus_clock_line_oe_n,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_n,
    output logic spi_clock
);

    // Software visible state
    logic [7:0] reload_value;
    logic [7:0] xfer_buf;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic stop_seen;
    logic buf_full;
    logic collision_flag;
    logic port_irq_flag;
    // Sequencer state
    i2cms_state_t state;
    logic [4:0] phase_cnt;
    logic scl_low;
    logic sda_low;
    logic sda_seen_hi;
    logic spi_clk;

    logic [7:0] next_reload_value;
    logic [7:0] next_xfer_buf;
    logic [7:0] next_ctl1;
    logic [7:0] next_ctl2;
    logic [7:0] next_ctl3;
    logic next_stop_seen;
    logic next_buf_full;
    logic next_collision_flag;
    logic next_port_irq_flag;
    i2cms_state_t next_state;
    logic [4:0] next_phase_cnt;
    logic next_scl_low;
    logic next_sda_low;
    logic next_sda_seen_hi;
    logic next_spi_clk;
    logic [31:0] next_prdata;

    // Synchronisers for the bus lines
    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;

    // Decoded controls and events
    logic enabled;
    logic i2c_mode;
    logic spi_mode;
    logic rc_load;
    logic rc_timeout;
    logic collide;
    logic finish_done;
    logic wcol_set;
    logic wr;
    logic setup;
    logic mapped;

    assign enabled = ctl1[`I2CMS_EN_BIT];
    assign i2c_mode = enabled && (ctl1[3:0] == `I2CMS_MODE_I2C_MST);
    assign spi_mode = enabled && (ctl1[3:0] == `I2CMS_MODE_SPI_MST);
    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;

    // Zero wait state slave
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Open drain pins: drive low or release
    assign bus_clock_line_o = 1'b0;
    assign bus_data_line_o = 1'b0;
    assign bus_clock_line_oe_n = !scl_low;
    assign bus_data_line_oe_n = !sda_low;
    assign spi_clock = spi_clk;

    // Address decode
    always_comb begin
        if (paddr == `I2CMS_ADDR_RELOAD) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_BUF) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_CTL1) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_CTL2) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_CTL3) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_STAT) begin
            mapped = 1'b1;
        end else if (paddr == `I2CMS_ADDR_FLAGS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Shared rate counter
    i2cms_rate_counter u_rate_counter (
        .pclk(pclk),
        .presetn(presetn),
        .load(rc_load),
        .reload_value(reload_value),
        .timeout(rc_timeout)
    );

    // Two flops before any logic sees the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= bus_clock_line_i;
            scl_sync <= scl_meta;
            sda_meta <= bus_data_line_i;
            sda_sync <= sda_meta;
        end
    end

    // Sequencer, register writes and read data
    always_comb begin
        next_reload_value = reload_value;
        next_xfer_buf = xfer_buf;
        next_ctl1 = ctl1;
        next_ctl2 = ctl2;
        next_ctl3 = ctl3;
        next_stop_seen = stop_seen;
        next_buf_full = buf_full;
        next_collision_flag = collision_flag;
        next_port_irq_flag = port_irq_flag;
        next_state = state;
        next_phase_cnt = phase_cnt;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_sda_seen_hi = sda_seen_hi;
        next_spi_clk = spi_clk;
        next_prdata = prdata;
        rc_load = 1'b0;
        collide = 1'b0;
        finish_done = 1'b0;
        wcol_set = 1'b0;

        case (state)
            I2CMS_IDLE: begin
                if (i2c_mode && ctl2[`I2CMS_FINISH_BIT]) begin
                    next_sda_low = 1'b1;
                    next_state = I2CMS_PULL_SDA;
                end
            end
            I2CMS_SHIFT: begin
                // Each timeout ends one half period
                if (rc_timeout) begin
                    if (i2c_mode) begin
                        next_scl_low = !scl_low;
                    end else begin
                        next_spi_clk = !spi_clk;
                    end
                    if ((i2c_mode && phase_cnt == `I2CMS_PHASES_I2C - 5'h01) ||
                        (!i2c_mode && phase_cnt == `I2CMS_PHASES_SPI - 5'h01)) begin
                        next_buf_full = 1'b0;
                        next_state = I2CMS_IDLE;
                    end else begin
                        rc_load = 1'b1;
                        next_phase_cnt = phase_cnt + 5'h01;
                    end
                end
            end
            I2CMS_PULL_SDA: begin
                if (!sda_sync) begin
                    rc_load = 1'b1;
                    next_state = I2CMS_SDA_CNT;
                end
            end
            I2CMS_SDA_CNT: begin
                if (rc_timeout) begin
                    next_scl_low = 1'b0;
                    next_state = I2CMS_REL_SCL;
                end
            end
            I2CMS_REL_SCL: begin
                // Wait out clock stretching by others
                if (scl_sync) begin
                    rc_load = 1'b1;
                    next_state = I2CMS_SCL_CNT;
                end
            end
            I2CMS_SCL_CNT: begin
                if (!scl_sync) begin
                    collide = 1'b1;
                end else if (rc_timeout) begin
                    next_sda_low = 1'b0;
                    next_sda_seen_hi = 1'b0;
                    rc_load = 1'b1;
                    next_state = I2CMS_REL_SDA;
                end
            end
            I2CMS_REL_SDA: begin
                if (!sda_seen_hi && !scl_sync) begin
                    collide = 1'b1;
                end else begin
                    if (sda_sync && scl_sync) begin
                        next_sda_seen_hi = 1'b1;
                        next_stop_seen = 1'b1;
                    end
                    if (rc_timeout) begin
                        if (!sda_sync) begin
                            collide = 1'b1;
                        end else begin
                            finish_done = 1'b1;
                            next_state = I2CMS_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_state = I2CMS_IDLE;
            end
        endcase

        // Abort on collision
        if (collide) begin
            next_sda_low = 1'b0;
            next_scl_low = 1'b0;
            next_state = I2CMS_IDLE;
        end

        // Disabling the port releases both lines and clears stop seen, buffer full and the sequencer state
        if (!enabled) begin
            next_sda_low = 1'b0;
            next_scl_low = 1'b0;
            next_stop_seen = 1'b0;
            next_buf_full = 1'b0;
            next_state = I2CMS_IDLE;
        end

        // Hardware clears the request before software writes land
        if (collide || finish_done) begin
            next_ctl2[`I2CMS_FINISH_BIT] = 1'b0;
        end

        // Register writes
        if (wr) begin
            if (paddr == `I2CMS_ADDR_RELOAD) begin
                next_reload_value = pwdata[7:0];
            end else if (paddr == `I2CMS_ADDR_BUF) begin
                if (state != I2CMS_IDLE || !(i2c_mode || spi_mode)) begin
                    wcol_set = 1'b1;
                end else begin
                    next_xfer_buf = pwdata[7:0];
                    next_buf_full = 1'b1;
                    rc_load = 1'b1;
                    next_phase_cnt = `I2CMS_RST_PHASE;
                    next_state = I2CMS_SHIFT;
                    if (i2c_mode) begin
                        next_scl_low = 1'b1;
                    end else begin
                        next_spi_clk = ctl1[`I2CMS_CKP_BIT];
                    end
                end
            end else if (paddr == `I2CMS_ADDR_CTL1) begin
                next_ctl1 = pwdata[7:0];
                next_ctl1[`I2CMS_WCOL_BIT] = ctl1[`I2CMS_WCOL_BIT] && pwdata[`I2CMS_WCOL_BIT];
            end else if (paddr == `I2CMS_ADDR_CTL2) begin
                next_ctl2 = pwdata[7:0];
            end else if (paddr == `I2CMS_ADDR_CTL3) begin
                next_ctl3 = pwdata[7:0];
            end else if (paddr == `I2CMS_ADDR_FLAGS) begin
                if (pwdata[`I2CMS_COLL_BIT]) begin
                    next_collision_flag = 1'b0;
                end
                if (pwdata[`I2CMS_IRQ_BIT]) begin
                    next_port_irq_flag = 1'b0;
                end
            end
        end

        // Hardware sets win over software clears
        if (collide) begin
            next_collision_flag = 1'b1;
        end
        if (finish_done) begin
            next_port_irq_flag = 1'b1;
        end
        if (wcol_set) begin
            next_ctl1[`I2CMS_WCOL_BIT] = 1'b1;
        end

        // Read data captured in the setup cycle
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (paddr == `I2CMS_ADDR_RELOAD) begin
                next_prdata[7:0] = reload_value;
            end else if (paddr == `I2CMS_ADDR_BUF) begin
                next_prdata[7:0] = xfer_buf;
            end else if (paddr == `I2CMS_ADDR_CTL1) begin
                next_prdata[7:0] = ctl1;
            end else if (paddr == `I2CMS_ADDR_CTL2) begin
                next_prdata[7:0] = ctl2;
            end else if (paddr == `I2CMS_ADDR_CTL3) begin
                next_prdata[7:0] = ctl3;
            end else if (paddr == `I2CMS_ADDR_STAT) begin
                next_prdata[`I2CMS_STOP_SEEN_BIT] = stop_seen;
                next_prdata[`I2CMS_BUSY_BIT] = (state == I2CMS_SHIFT);
                next_prdata[`I2CMS_BF_BIT] = buf_full;
            end else if (paddr == `I2CMS_ADDR_FLAGS) begin
                next_prdata[`I2CMS_COLL_BIT] = collision_flag;
                next_prdata[`I2CMS_IRQ_BIT] = port_irq_flag;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_value <= `I2CMS_RST8;
            xfer_buf <= `I2CMS_RST8;
            ctl1 <= `I2CMS_RST8;
            ctl2 <= `I2CMS_RST8;
            ctl3 <= `I2CMS_RST8;
            stop_seen <= 1'b0;
            buf_full <= 1'b0;
            collision_flag <= 1'b0;
            port_irq_flag <= 1'b0;
            state <= I2CMS_IDLE;
            phase_cnt <= `I2CMS_RST_PHASE;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            sda_seen_hi <= 1'b0;
            spi_clk <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            reload_value <= next_reload_value;
            xfer_buf <= next_xfer_buf;
            ctl1 <= next_ctl1;
            ctl2 <= next_ctl2;
            ctl3 <= next_ctl3;
            stop_seen <= next_stop_seen;
            buf_full <= next_buf_full;
            collision_flag <= next_collision_flag;
            port_irq_flag <= next_port_irq_flag;
            state <= next_state;
            phase_cnt <= next_phase_cnt;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            sda_seen_hi <= next_sda_seen_hi;
            spi_clk <= next_spi_clk;
            prdata <= next_prdata;
        end
    end

endmodule

// [dv/i2cms_stop_monitor.sv]
`timescale 1ns/1ns
module i2cms_stop_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bus_clock_line_i,
    input wire logic bus_clock_line_o,
    input wire logic bus_clock_line_oe_n,
    input wire logic bus_data_line_i,
    input wire logic bus_data_line_o,
    input wire logic bus_data_line_oe_n,
    input wire logic spi_clock
);
    logic [7:0] reload_q, ctl_q, low_cnt, held;
    logic scl_q, wr;
    int ph;
    assign wr = psel && penable && pwrite;
    assign ph = 4 * (int'(reload_q) + 1);
    // Shadow registers and cycle counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= 8'h00;
            ctl_q <= 8'h00;
            low_cnt <= 8'h00;
            held <= 8'hff;
            scl_q <= 1'b1;
        end else begin
            if (wr && paddr == 8'h00) begin
                reload_q <= pwdata[7:0];
            end
            if (wr && paddr == 8'h08) begin
                ctl_q <= pwdata[7:0];
            end
            low_cnt <= bus_data_line_oe_n ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
            scl_q <= bus_clock_line_oe_n;
            held <= (scl_q != bus_clock_line_oe_n) ? 8'h00 : held + {7'h00, held != 8'hff};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_stop_start;
        wr && paddr == 8'h0c && pwdata[2] && ctl_q[5] && ctl_q[3:0] == 4'h8
            && bus_data_line_oe_n |=> ##1 !bus_data_line_oe_n;
    endproperty
    a_stop_start: assert property (p_stop_start)
        else $error("stop did not pull data low");
    property p_hold_clock;
        $fell(bus_data_line_oe_n) |=> $stable(bus_clock_line_oe_n) [*3];
    endproperty
    a_hold_clock: assert property (p_hold_clock)
        else $error("clock moved before data seen low");
    property p_clock_coll;
        (bus_clock_line_oe_n && !bus_data_line_oe_n && !bus_clock_line_i) [*3]
            |-> ##[0:4] (bus_data_line_oe_n && bus_clock_line_oe_n);
    endproperty
    a_clock_coll: assert property (p_clock_coll)
        else $error("clock collision not aborted");
    property p_stop_len;
        $rose(bus_data_line_oe_n) && bus_clock_line_i
            |-> int'(low_cnt) >= 2 * ph && int'(low_cnt) <= 2 * ph + 16;
    endproperty
    a_stop_len: assert property (p_stop_len)
        else $error("stop length wrong");
    property p_released;
        $rose(bus_data_line_oe_n) && bus_clock_line_i
            |=> (bus_data_line_oe_n && bus_clock_line_oe_n) [*8];
    endproperty
    a_released: assert property (p_released)
        else $error("lines driven after stop");
    property p_phase;
        $changed(bus_clock_line_oe_n) && bus_data_line_oe_n && $past(bus_data_line_oe_n)
            |-> int'(held) + 2 >= ph;
    endproperty
    a_phase: assert property (p_phase)
        else $error("clock phase too short");
    property p_spi_mode;
        $changed(spi_clock) |-> ctl_q[3:0] == 4'ha || $past(ctl_q[3:0]) == 4'ha;
    endproperty
    a_spi_mode: assert property (p_spi_mode)
        else $error("spi clock moved outside spi mode");
    property p_err;
        psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
            8'h10, 8'h14, 8'h18});
    endproperty
    a_err: assert property (p_err)
        else $error("error response wrong");
    // Open drain outputs may only ever pull low
    property p_drive_low;
        !bus_clock_line_o && !bus_data_line_o;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("bus line driven high");
    c_stop: cover property ($rose(bus_data_line_oe_n) && bus_clock_line_i);
    c_abort: cover property ((bus_clock_line_oe_n && !bus_clock_line_i) [*3]);
    c_spi: cover property ($changed(spi_clock));
endmodule

bind i2cms_stop_core i2cms_stop_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_clock_line_i(bus_clock_line_i),
    .bus_clock_line_o(bus_clock_line_o), .bus_clock_line_oe_n(bus_clock_line_oe_n),
    .bus_data_line_i(bus_data_line_i), .bus_data_line_o(bus_data_line_o),
    .bus_data_line_oe_n(bus_data_line_oe_n), .spi_clock(spi_clock));

// [dv/i2cms_bus_model.sv]
`timescale 1ns/1ns
module i2cms_bus_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] mode,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    logic [7:0] cnt, next_cnt;
    // Cycles the device holds data low with the clock free
    always_comb begin
        next_cnt = 8'h00;
        if (!sda_oe_n && scl_oe_n) begin
            next_cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
    // Pulled-up lines; mode 1 drives a zero on data, mode 2 pulls clock mid-stop
    assign sda = sda_oe_n && mode != 2'h1;
    assign scl = scl_oe_n && !(mode == 2'h2 && cnt >= 8'h1a && cnt < 8'h20);
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
    logic pclk, pready, pslverr, err, scl_oe_n, sda_oe_n, scl, sda, spi_clock;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic scl_q = 1'b1, spi_q = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] pmode = 2'h0;
    logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    int n_fail = 0, comparisons = 0, scl_tog = 0, spi_tog = 0, base;

    i2cms_stop_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_clock_line_i(scl), .bus_clock_line_o(),
        .bus_clock_line_oe_n(scl_oe_n), .bus_data_line_i(sda), .bus_data_line_o(),
        .bus_data_line_oe_n(sda_oe_n), .spi_clock(spi_clock));
    i2cms_bus_model bus (.pclk(pclk), .presetn(presetn), .mode(pmode),
        .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Count moves of the clock drive and the spi clock
    always @(posedge pclk) begin
        scl_q <= scl_oe_n;
        spi_q <= spi_clock;
        if (scl_q !== scl_oe_n) scl_tog++;
        if (spi_q !== spi_clock) spi_tog++;
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task poll(input logic [7:0] a, input logic [31:0] m);
        do apb(1'b0, a, 32'h0); while ((rd & m) !== 32'h0);
    endtask
    task stop_case(input logic [1:0] m, input logic [31:0] fl);
        pmode <= m;
        wr(8'h0c, 32'h4);
        poll(8'h0c, 32'h4);
        rc(8'h18, fl);
        `CHK({scl_oe_n, sda_oe_n}, 2'b11)
        pmode <= 2'h0;
        wr(8'h18, 32'h3);
        rc(8'h18, 32'h0);
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rc(regs[i], 32'h0);
        apb(1'b1, 8'h1c, 32'hff);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        wr(8'h10, 32'h5a);
        rc(8'h10, 32'h5a);
        wr(8'h00, 32'h3);
        rc(8'h00, 32'h3);
        $display("test registers done");
        wr(8'h08, 32'h28);
        stop_case(2'h1, 32'h1);
        stop_case(2'h2, 32'h1);
        stop_case(2'h0, 32'h2);
        rc(8'h14, 32'h10);
        $display("test stop done");
        base = scl_tog;
        wr(8'h04, 32'ha5);
        rc(8'h14, 32'h15);
        wr(8'h04, 32'h3c);
        rc(8'h08, 32'ha8);
        rc(8'h04, 32'ha5);
        poll(8'h14, 32'h5);
        repeat (40) @(posedge pclk);
        // Pulled low by the write, then 18 half periods; clock ends held low
        `CHK(scl_tog - base, 19)
        `CHK(scl_oe_n, 1'b0)
        stop_case(2'h0, 32'h2);
        $display("test bus clocking done");
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h3a);
        rc(8'h08, 32'h3a);
        base = spi_tog;
        wr(8'h04, 32'h81);
        poll(8'h14, 32'h5);
        // Jump to the idle level at the write, then 16 edges
        `CHK(spi_tog - base, 17)
        `CHK(spi_clock, 1'b1)
        $display("test spi clocking done");
        end_sim;
    end
endmodule
